// ===== logic/nvc_pkg.sv
// Package for the host-side nonvolatile RAM controller: timing and sequences.
`default_nettype none
package nvc_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CLK_NS = 25;
	// Least chip-select low time for an initiation read, in ns.
	localparam int CS_LOW_NS = 45;
	localparam int CS_LOW_CYC = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
	// Least deselect time between accesses, in ns.
	localparam int CS_HIGH_NS = 45;
	localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
	// Longest store time, in ms; the host waits it out in full.
	localparam int NV_SAVE_TIME_MS = 10;
	localparam int NV_SAVE_CYC = NV_SAVE_TIME_MS * 1000000 / CLK_NS;
	// Longest software recall time, in us.
	localparam int RECALL_TIME_US = 20;
	localparam int RECALL_CYC = RECALL_TIME_US * 1000 / CLK_NS;
	// Longest power-up reload time, in us.
	localparam int POWERUP_RELOAD_TIME_US = 550;
	localparam int POWERUP_RELOAD_CYC = POWERUP_RELOAD_TIME_US * 1000 / CLK_NS;
	localparam logic [12:0] SEQ_A0 = 13'h0000;
	localparam logic [12:0] SEQ_A1 = 13'h1555;
	localparam logic [12:0] SEQ_A2 = 13'h0AAA;
	localparam logic [12:0] SEQ_A3 = 13'h1FFF;
	localparam logic [12:0] SEQ_A4 = 13'h10F0;
	localparam logic [12:0] SEQ_STORE = 13'h0F0F;
	localparam logic [12:0] SEQ_RECALL = 13'h0F0E;
	localparam logic [2:0] SEQ_LAST = 3'h5;
	localparam logic [23:0] CNT_ZERO = 24'h00_0000;

	typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_STORE, CMD_RECALL}
		nvc_cmd_e;
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_BUSY} nvc_state_e;

	// Request from the user side.
	typedef struct packed {
		nvc_cmd_e cmd;
		logic [12:0] addr;
		logic [7:0] wdata;
	} nvc_req_s;

	// Device pin drive.
	typedef struct packed {
		logic cs_n;
		logic we_n;
		logic oe_n;
		logic [12:0] addr;
		logic [7:0] dout;
		logic doe;
	} nvc_pins_s;

	function automatic logic [12:0] seq_addr(input logic [2:0] idx,
		input logic recall);
		case (idx)
			3'h0: seq_addr = SEQ_A0;
			3'h1: seq_addr = SEQ_A1;
			3'h2: seq_addr = SEQ_A2;
			3'h3: seq_addr = SEQ_A3;
			3'h4: seq_addr = SEQ_A4;
			default: seq_addr = recall ? SEQ_RECALL : SEQ_STORE;
		endcase
	endfunction : seq_addr
endpackage : nvc_pkg
`default_nettype wire

// ===== logic/nvc_host.sv
// Host controller that drives the nonvolatile RAM pins for access, store and recall.
//
// Operation
// - Store: five reads 0000..10F0 then 0F0F.
// - Recall: same five reads then 0F0E.
// - Write strobe held high during sequence.
// - Address stable through write, output enable high.
// - No write active when power-up recall ends.
`timescale 1ns/1ps
`default_nettype none
module nvc_host
	import nvc_pkg::*;
#(
	parameter int SAVE_CYC = NV_SAVE_CYC,
	parameter int RELOAD_CYC = POWERUP_RELOAD_CYC
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire nvc_req_s req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic busy,
	output nvc_pins_s pins,
	input wire logic [7:0] data_pins_in,
	input wire logic hw_store_busy_n_in,
	output logic hw_store_busy_n_out,
	output logic hw_store_busy_n_oe
);

	////////////////////////////////////////////////////////////////////////
	// The busy line is synchronised; a level counts once stages 2 and 3 agree.
	logic [2:0] hsb_sync;
	logic hsb_low;
	logic next_hsb_low;

	always_comb
	begin
		next_hsb_low = hsb_low;
		if (hsb_sync[1] == hsb_sync[2])
			next_hsb_low = ~hsb_sync[2];
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			hsb_sync <= 3'h7;
			hsb_low <= 1'b0;
		end
		else
		begin
			hsb_sync <= {hsb_sync[1:0], hw_store_busy_n_in};
			hsb_low <= next_hsb_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencer.
	nvc_state_e state;
	nvc_state_e next_state;
	nvc_req_s cur;
	nvc_req_s next_cur;
	logic [2:0] step;
	logic [2:0] next_step;
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic powerup;
	logic next_powerup;
	nvc_pins_s next_pins;
	logic next_req_ready;
	logic next_rsp_valid;
	logic [7:0] next_rsp_data;
	logic next_busy;
	logic is_seq;

	assign is_seq = (cur.cmd == CMD_STORE) || (cur.cmd == CMD_RECALL);

	always_comb
	begin
		next_state = state;
		next_cur = cur;
		next_step = step;
		next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - 24'h00_0001;
		next_powerup = powerup;
		next_pins = pins;
		next_req_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		next_busy = busy;
		case (state)
			ST_IDLE:
			begin
				next_pins.cs_n = 1'b1;
				next_pins.we_n = 1'b1;
				next_pins.oe_n = 1'b1;
				next_pins.doe = 1'b0;
				// Nothing is issued while the device holds its busy line low.
				next_busy = hsb_low;
				next_req_ready = ~hsb_low;
				if (req_valid && req_ready)
				begin
					next_cur = req;
					next_step = 3'h0;
					next_busy = 1'b1;
					next_state = ST_SETUP;
					next_req_ready = 1'b0;
				end
			end
			ST_SETUP:
			begin
				// Address and write strobe settle before chip select falls.
				next_pins.addr = is_seq ? seq_addr(step, cur.cmd == CMD_RECALL)
					: cur.addr;
				next_pins.we_n = 1'b1;
				next_pins.oe_n = (cur.cmd == CMD_READ) ? 1'b0 : 1'b1;
				next_pins.dout = cur.wdata;
				next_pins.doe = (cur.cmd == CMD_WRITE);
				next_state = ST_STROBE;
				next_cnt = 24'(CS_LOW_CYC);
			end
			ST_STROBE:
			begin
				// Chip select controls every cycle, sequence reads included.
				next_pins.cs_n = 1'b0;
				next_pins.we_n = (cur.cmd != CMD_WRITE);
				if (cnt == CNT_ZERO && !pins.cs_n)
				begin
					next_pins.cs_n = 1'b1;
					next_pins.we_n = 1'b1;
					next_rsp_data = data_pins_in;
					next_cnt = 24'(CS_HIGH_CYC);
					next_state = ST_GAP;
				end
			end
			ST_GAP:
			begin
				next_pins.oe_n = 1'b1;
				next_pins.doe = 1'b0;
				if (cnt == CNT_ZERO)
				begin
					// Reads follow back to back; no other access cuts in.
					if (is_seq && step != SEQ_LAST)
					begin
						next_step = step + 3'h1;
						next_state = ST_SETUP;
					end
					else if (is_seq)
					begin
						// Device erases/programs or clears/reloads internally.
						next_cnt = (cur.cmd == CMD_STORE) ? 24'(SAVE_CYC)
							: 24'(RECALL_CYC);
						next_state = ST_BUSY;
					end
					else
					begin
						next_rsp_valid = 1'b1;
						next_busy = 1'b0;
						next_state = ST_IDLE;
					end
				end
			end
			ST_BUSY:
			begin
				// Pins stay idle for the full worst-case time.
				if (cnt == CNT_ZERO)
				begin
					next_rsp_valid = !powerup;
					next_powerup = 1'b0;
					next_busy = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			// Power-up reload is waited out with every strobe inactive.
			state <= ST_BUSY;
			cnt <= 24'(RELOAD_CYC);
			powerup <= 1'b1;
			cur <= '0;
			step <= 3'h0;
			pins <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
				addr: 13'h0000, dout: 8'h00, doe: 1'b0};
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			busy <= 1'b1;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			powerup <= next_powerup;
			cur <= next_cur;
			step <= next_step;
			pins <= next_pins;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			busy <= next_busy;
		end
	end

	// The host never pulls the busy line; it only watches it.
	always_ff @(posedge ref_clk)
	begin
		hw_store_busy_n_out <= 1'b1;
		hw_store_busy_n_oe <= 1'b0;
	end

endmodule : nvc_host
`default_nettype wire

// ===== bench/nvc_host_checker.sv
// Checker of the host controller's pin and handshake timing.
`timescale 1ns/1ps
`default_nettype none
module nvc_chk
	import nvc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic busy,
	input wire nvc_pins_s pins,
	input wire logic hw_store_busy_n_oe,
	input wire logic hw_store_busy_n_in
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	property p_rdy; req_ready |-> !busy; endproperty
	a_rdy: assert property (p_rdy) else $error("ready when busy");
	property p_oe; !hw_store_busy_n_oe; endproperty
	a_oe: assert property (p_oe) else $error("busy line driven");
	property p_rsp; rsp_valid |=> !rsp_valid; endproperty
	a_rsp: assert property (p_rsp) else $error("long response");
	property p_wr; !pins.we_n |-> !pins.cs_n && pins.oe_n; endproperty
	a_wr: assert property (p_wr) else $error("bad write");
	property p_cs; $fell(pins.cs_n) |-> !pins.cs_n [*2] ##1 pins.cs_n;
	endproperty
	a_cs: assert property (p_cs) else $error("select width");
	property p_ad; !pins.cs_n ##1 !pins.cs_n |-> $stable(pins.addr);
	endproperty
	a_ad: assert property (p_ad) else $error("address moved");
	property p_rd; !pins.cs_n && pins.we_n |-> !pins.doe; endproperty
	a_rd: assert property (p_rd) else $error("read contention");
	property p_tk; req_valid && req_ready |=> !req_ready; endproperty
	a_tk: assert property (p_tk) else $error("double take");
	// The synchroniser needs several cycles before ready can drop.
	property p_stall; !hw_store_busy_n_in [*5] |=> !req_ready; endproperty
	a_stall: assert property (p_stall) else $error("ready in store");
	property p_seq; !pins.cs_n && pins.oe_n && !pins.doe |-> pins.we_n;
	endproperty
	a_seq: assert property (p_seq) else $error("strobe in sequence");
endmodule : nvc_chk
bind nvc_host nvc_chk u_chk(.ref_clk, .sys_rst, .req_valid, .req_ready,
	.rsp_valid, .busy, .pins, .hw_store_busy_n_oe, .hw_store_busy_n_in);
`default_nettype wire

// ===== bench/nvc_dev.sv
// Behavioural nonvolatile RAM device answering the host's pins.
`timescale 1ns/1ps
`default_nettype none
module nvc_dev
	import nvc_pkg::*;
(
	input wire logic ref_clk,
	input wire nvc_pins_s pins,
	output logic [7:0] dq,
	output logic bsy_n
);
	logic [7:0] sram [8192];
	logic [7:0] nv [8192];
	logic [12:0] sq [6] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_STORE};
	logic [7:0] last = 8'h00;
	logic pcs = 1'b1;
	logic pwe = 1'b1;
	logic rd;
	int st = 0;
	int t = 0;
	initial
	begin
		for (int i = 0; i < 8192; i++)
			nv[i] = 8'(i * 7);
		sram = nv;
	end
	assign rd = !pins.cs_n && !pins.oe_n && pins.we_n && t == 0;
	// A released bus shows the inverse byte so stale data cannot pass.
	assign dq = rd ? sram[pins.addr] : ~last;
	assign bsy_n = !(t > 0 && st == 6);
	always @(posedge ref_clk)
	begin
		if (rd)
			last <= dq;
		if (t > 0)
		begin
			t <= t - 1;
			if (t == 1)
				st <= 0;
		end
		else if (pcs && !pins.cs_n)
		begin
			if (!pins.we_n)
				st <= 0;
			else if (st == 5 && pins.addr == SEQ_RECALL)
			begin
				sram = '{default: 8'h00};
				sram = nv;
				st <= 7;
				t <= 600;
			end
			else if (pins.addr == sq[st])
			begin
				st <= st + 1;
				if (st == 5)
				begin
					nv = '{default: 8'h00};
					nv = sram;
					t <= 40;
				end
			end
			else
				st <= pins.addr == SEQ_A0;
		end
		if (t == 0 && !pcs && !pwe && (pins.cs_n || pins.we_n))
			sram[pins.addr] = pins.dout;
		pcs <= pins.cs_n;
		pwe <= pins.we_n;
	end
endmodule : nvc_dev
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench of the host controller against a device model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top
	import nvc_pkg::*;
;
	logic ref_clk = 0;
	logic sys_rst = 1;
	logic req_valid = 0;
	nvc_req_s req = '0;
	logic req_ready, rsp_valid, busy, bo, boe, bsy_n;
	logic [7:0] rsp_data, dq;
	nvc_pins_s pins;
	wire logic bl = bsy_n & (!boe | bo);
	int num_errors = 0, n_compared = 0, seed = 3, st = 0, a = 0;
	int mem[8192], nvm[8192];
	int sqa[6] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_STORE};
	nvc_host #(.SAVE_CYC(50), .RELOAD_CYC(20)) dut(.ref_clk, .sys_rst,
		.req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .busy, .pins,
		.data_pins_in(dq), .hw_store_busy_n_in(bl),
		.hw_store_busy_n_out(bo), .hw_store_busy_n_oe(boe));
	nvc_dev u_dev(.ref_clk, .pins, .dq, .bsy_n);
	initial
		forever #12.5 ref_clk = ~ref_clk;
	task automatic end_sim;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic op(input nvc_cmd_e c, input int ad, input int d);
		int k;
		k = 0;
		@(negedge ref_clk);
		req_valid = 1;
		req = '{c, ad[12:0], d[7:0]};
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (req_ready !== 1'b1 && k < 3000);
		@(negedge ref_clk);
		req_valid = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (rsp_valid !== 1'b1 && k < 3000);
		if (k >= 3000)
			num_errors++;
		// The sequence-ending read returns nothing, so it is not compared.
		if (c == CMD_READ && st == 5 && ad == sqa[5])
		begin
			st = 0;
			nvm = mem;
		end
		else if (c == CMD_READ)
		begin
			`CHK(rsp_data, 8'(mem[ad]))
			st = ad == sqa[st] ? st + 1 : ad == 0;
		end
		else
			st = 0;
		if (c == CMD_WRITE)
			mem[ad] = d[7:0];
		if (c == CMD_STORE)
			nvm = mem;
		if (c == CMD_RECALL)
			mem = nvm;
	endtask : op
	initial
	begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'(i * 7);
		nvm = mem;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 0;
		op(CMD_READ, 5, 0);
		repeat (8)
		begin
			a = $random(seed) & 16'h1FFF;
			op(CMD_WRITE, a, $random(seed));
			op(CMD_READ, a, 0);
		end
		op(CMD_STORE, 0, 0);
		op(CMD_WRITE, a, 8'h3C);
		repeat (2) op(CMD_RECALL, 0, 0);
		op(CMD_READ, a, 0);
		op(CMD_READ, 0, 0);
		foreach (sqa[i])
			op(CMD_READ, sqa[i], 0);
		op(CMD_WRITE, a, 8'h5A);
		for (int i = 0; i < 5; i++)
			op(CMD_READ, sqa[i], 0);
		op(CMD_WRITE, SEQ_STORE, 8'hA5);
		op(CMD_RECALL, 0, 0);
		op(CMD_READ, a, 0);
		op(CMD_READ, SEQ_STORE, 0);
		end_sim();
	end
	initial
	begin
		#1000000;
		num_errors++;
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
